// >>> hw/cmbe_params.svh
// Constant definitions for the multiply, compare and branch execution core.
// Summary of operation
// - Zero/sign test: flags only, one cycle
// - Integer multiplies write pair one:zero, two cycles
// - Fractional multiplies shift product left, two cycles
// - Relative branch adds offset plus one, two cycles
// - Indirect branch loads pointer pair, two cycles
// - Extended indirect branch uses high register, two cycles
// - Indirect call loads pointer pair, four cycles
// - Extended indirect call, four cycles
// - Direct call loads absolute address, five cycles
// - Return reloads counter from stack, five cycles
// - Interrupt return also sets interrupt enable
// - Compare-skip-equal skips next when registers match
// - Register compares set six flags, one cycle
// - Immediate compare sets six flags, one cycle
// - Register bit skips on clear or set
// - I/O bit skips on clear or set
// - Flag branches: one cycle untaken, two taken
`ifndef CMBE_PARAMS_SVH
`define CMBE_PARAMS_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define CMBE_CTRL_OFFS      8'h00
`define CMBE_FLAGS_OFFS     8'h04
`define CMBE_PC_OFFS        8'h08
`define CMBE_EIH_OFFS       8'h0C
`define CMBE_CTRL_RST       1'h0
`define CMBE_FLAGS_RST      8'h00
`define CMBE_EIH_RST        8'h00
`define CMBE_PC_RST         24'h000000

// ****************************************************************
// Status flag positions
// ****************************************************************
`define CMBE_FLAG_C         0
`define CMBE_FLAG_Z         1
`define CMBE_FLAG_N         2
`define CMBE_FLAG_V         3
`define CMBE_FLAG_S         4
`define CMBE_FLAG_H         5
`define CMBE_FLAG_I         7

// ****************************************************************
// Cycle counts
// ****************************************************************
`define CMBE_CYC_ONE        3'h1
`define CMBE_CYC_TWO        3'h2
`define CMBE_CYC_THREE      3'h3
`define CMBE_CYC_FOUR       3'h4
`define CMBE_CYC_FIVE       3'h5

`endif

// >>> hw/cmbe_pkg.sv
// Types shared by the execution core and its surroundings.
package cmbe_pkg;

	typedef enum logic [4:0]
	{
		OP_ZERO_SIGN_TEST                     = 5'h00,
		OP_PRODUCT_UNSIGNED                   = 5'h01,
		OP_PRODUCT_SIGNED                     = 5'h02,
		OP_PRODUCT_SIGNED_BY_UNSIGNED         = 5'h03,
		OP_FRACTION_PRODUCT_UNSIGNED          = 5'h04,
		OP_FRACTION_PRODUCT_SIGNED            = 5'h05,
		OP_FRACTION_PRODUCT_MIXED             = 5'h06,
		OP_RELATIVE_BRANCH                    = 5'h07,
		OP_INDIRECT_BRANCH                    = 5'h08,
		OP_EXTENDED_INDIRECT_BRANCH           = 5'h09,
		OP_INDIRECT_SUBROUTINE_CALL           = 5'h0A,
		OP_EXTENDED_INDIRECT_SUBROUTINE_CALL  = 5'h0B,
		OP_DIRECT_SUBROUTINE_CALL             = 5'h0C,
		OP_SUBROUTINE_RETURN                  = 5'h0D,
		OP_INTERRUPT_RETURN                   = 5'h0E,
		OP_COMPARE_SKIP_EQUAL                 = 5'h0F,
		OP_REGISTER_COMPARE                   = 5'h10,
		OP_REGISTER_COMPARE_CARRY             = 5'h11,
		OP_IMMEDIATE_COMPARE                  = 5'h12,
		OP_SKIP_REG_BIT_CLEAR                 = 5'h13,
		OP_SKIP_REG_BIT_SET                   = 5'h14,
		OP_SKIP_IO_BIT_CLEAR                  = 5'h15,
		OP_SKIP_IO_BIT_SET                    = 5'h16,
		OP_BRANCH_FLAG_SET                    = 5'h17,
		OP_BRANCH_FLAG_CLEAR                  = 5'h18
	} cmbe_op_type;

	typedef struct packed
	{
		cmbe_op_type  op;
		logic [7:0]   rd_val;
		logic [7:0]   rr_val;
		logic [7:0]   imm;
		logic [11:0]  offset;
		logic [2:0]   bit_sel;
		logic [23:0]  abs_addr;
		logic         next_two_words;
	} cmbe_instr_type;

	typedef struct packed
	{
		logic         valid;
		logic [15:0]  data;
	} cmbe_pair_wr_type;

	typedef struct packed
	{
		logic         push;
		logic         pop;
		logic [23:0]  push_addr;
	} cmbe_stack_type;

	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b01,
		ST_BUSY = 2'b10
	} cmbe_state_type;

endpackage : cmbe_pkg

// >>> hw/cmbe_core.sv
// Execution core for multiplies, compares, skips, branches, calls and returns.
//
// Chosen here: the AHB-Lite slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "cmbe_params.svh"

module cmbe_core
(
	// Clock and reset
	input  wire logic                     i_mclk,
	input  wire logic                     i_rst_n,
	// Instruction handshake
	input  wire logic                     i_instr_valid,
	input  wire cmbe_pkg::cmbe_instr_type i_instr,
	output logic                          o_instr_ready,
	output logic                          o_done,
	// Operand sources
	input  wire logic [15:0]              i_pointer_pair,
	input  wire logic [7:0]               i_io_byte,
	input  wire logic [23:0]              i_stack_addr,
	// Results
	output cmbe_pkg::cmbe_pair_wr_type    o_pair_wr,
	output cmbe_pkg::cmbe_stack_type      o_stack,
	output logic [23:0]                   o_pc,
	output logic [7:0]                    o_status_flags,
	// AHB-Lite slave
	input  wire logic                     i_hsel,
	input  wire logic [31:0]              i_haddr,
	input  wire logic [1:0]               i_htrans,
	input  wire logic                     i_hwrite,
	input  wire logic [2:0]               i_hsize,
	input  wire logic [31:0]              i_hwdata,
	input  wire logic                     i_hready,
	output logic                          o_hreadyout,
	output logic                          o_hresp,
	output logic [31:0]                   o_hrdata
);

	// ****************************************************************
	// Helper functions
	// ****************************************************************
	function automatic logic [7:0] sub_flags(input logic [7:0] a, input logic [7:0] b,
		input logic cin, input logic [7:0] old, input logic chain_z);
		logic [7:0] r;
		logic [7:0] f;
		logic       n;
		logic       v;
		r = a - b - {7'h00, cin};
		f = old;
		n = r[7];
		v = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
		f[`CMBE_FLAG_C] = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
		f[`CMBE_FLAG_H] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
		f[`CMBE_FLAG_N] = n;
		f[`CMBE_FLAG_V] = v;
		f[`CMBE_FLAG_S] = n ^ v;
		f[`CMBE_FLAG_Z] = (r == 8'h00) & (~chain_z | old[`CMBE_FLAG_Z]);
		return f;
	endfunction : sub_flags

	function automatic logic [15:0] product(input logic [7:0] a, input logic [7:0] b,
		input logic a_signed, input logic b_signed);
		logic [15:0] ea;
		logic [15:0] eb;
		ea = {{8{a_signed & a[7]}}, a};
		eb = {{8{b_signed & b[7]}}, b};
		return ea * eb;
	endfunction : product

	function automatic logic [23:0] rel_target(input logic [23:0] pc, input logic [11:0] k);
		return pc + {{12{k[11]}}, k} + 24'h000001;
	endfunction : rel_target

	// ****************************************************************
	// Bus slave
	// ****************************************************************
	logic        ctrl_run_ff;
	logic [7:0]  eih_ff;
	logic [7:0]  flags_ff;
	logic [23:0] pc_ff;
	logic        wr_pend_ff;
	logic [7:0]  wr_addr_ff;
	logic [31:0] hrdata_ff;
	logic        addr_phase;
	logic        sw_flag_wr;

	// Every access completes with no wait state and an OKAY response.
	assign o_hreadyout = 1'b1;
	assign o_hresp     = 1'b0;
	assign o_hrdata    = hrdata_ff;
	assign addr_phase  = i_hsel & i_hready & i_htrans[1];
	assign sw_flag_wr  = wr_pend_ff & (wr_addr_ff == `CMBE_FLAGS_OFFS);

	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			wr_pend_ff <= 1'b0;
			wr_addr_ff <= 8'h00;
		end
		else if (i_hready)
		begin
			wr_pend_ff <= addr_phase & i_hwrite & (i_hsize == 3'h2);
			wr_addr_ff <= i_haddr[7:0];
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			hrdata_ff <= 32'h00000000;
		else if (addr_phase & ~i_hwrite)
		begin
			case (i_haddr[7:0])
				`CMBE_CTRL_OFFS:  hrdata_ff <= {31'h00000000, ctrl_run_ff};
				`CMBE_FLAGS_OFFS: hrdata_ff <= {24'h000000, flags_ff};
				`CMBE_PC_OFFS:    hrdata_ff <= {8'h00, pc_ff};
				`CMBE_EIH_OFFS:   hrdata_ff <= {24'h000000, eih_ff};
				default:          hrdata_ff <= 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			ctrl_run_ff <= `CMBE_CTRL_RST;
			eih_ff      <= `CMBE_EIH_RST;
		end
		else if (wr_pend_ff)
		begin
			if (wr_addr_ff == `CMBE_CTRL_OFFS)
				ctrl_run_ff <= i_hwdata[0];
			if (wr_addr_ff == `CMBE_EIH_OFFS)
				eih_ff <= i_hwdata[7:0];
		end
	end

	// ****************************************************************
	// Execution
	// ****************************************************************
	cmbe_pkg::cmbe_state_type state_ff;
	cmbe_pkg::cmbe_state_type nxt_state;
	logic [2:0]               wait_ff;
	logic [2:0]               cycles;
	logic                     accept;
	logic [23:0]              nxt_pc;
	logic [7:0]               nxt_flags;
	logic                     do_pair_wr;
	logic [15:0]              pair_data;
	logic                     do_push;
	logic                     do_pop;
	logic [23:0]              push_addr;
	logic [15:0]              prod;
	logic                     skip_hit;
	logic                     fraction;
	logic                     is_skip;

	assign o_instr_ready = ctrl_run_ff & (state_ff == cmbe_pkg::ST_IDLE);
	assign accept        = o_instr_ready & i_instr_valid;

	always_comb
	begin
		nxt_pc     = pc_ff + 24'h000001;
		nxt_flags  = flags_ff;
		cycles     = `CMBE_CYC_ONE;
		do_pair_wr = 1'b0;
		do_push    = 1'b0;
		do_pop     = 1'b0;
		push_addr  = pc_ff + 24'h000001;
		skip_hit   = 1'b0;
		is_skip    = 1'b0;
		fraction   = 1'b0;
		prod       = 16'h0000;
		pair_data  = 16'h0000;
		case (i_instr.op)
			cmbe_pkg::OP_ZERO_SIGN_TEST:
			begin
				// Value ANDed with itself is unchanged, so no write back.
				nxt_flags[`CMBE_FLAG_Z] = (i_instr.rd_val == 8'h00);
				nxt_flags[`CMBE_FLAG_N] = i_instr.rd_val[7];
				nxt_flags[`CMBE_FLAG_V] = 1'b0;
				nxt_flags[`CMBE_FLAG_S] = i_instr.rd_val[7];
			end
			cmbe_pkg::OP_PRODUCT_UNSIGNED, cmbe_pkg::OP_PRODUCT_SIGNED,
			cmbe_pkg::OP_PRODUCT_SIGNED_BY_UNSIGNED,
			cmbe_pkg::OP_FRACTION_PRODUCT_UNSIGNED,
			cmbe_pkg::OP_FRACTION_PRODUCT_SIGNED, cmbe_pkg::OP_FRACTION_PRODUCT_MIXED:
			begin
				fraction = (i_instr.op == cmbe_pkg::OP_FRACTION_PRODUCT_UNSIGNED) |
					(i_instr.op == cmbe_pkg::OP_FRACTION_PRODUCT_SIGNED) |
					(i_instr.op == cmbe_pkg::OP_FRACTION_PRODUCT_MIXED);
				prod = product(i_instr.rd_val, i_instr.rr_val,
					(i_instr.op != cmbe_pkg::OP_PRODUCT_UNSIGNED) &
					(i_instr.op != cmbe_pkg::OP_FRACTION_PRODUCT_UNSIGNED),
					(i_instr.op == cmbe_pkg::OP_PRODUCT_SIGNED) |
					(i_instr.op == cmbe_pkg::OP_FRACTION_PRODUCT_SIGNED));
				// Carry is taken from the unshifted product's top bit.
				pair_data  = fraction ? {prod[14:0], 1'b0} : prod;
				do_pair_wr = 1'b1;
				nxt_flags[`CMBE_FLAG_C] = prod[15];
				nxt_flags[`CMBE_FLAG_Z] = (pair_data == 16'h0000);
				cycles = `CMBE_CYC_TWO;
			end
			cmbe_pkg::OP_RELATIVE_BRANCH:
			begin
				nxt_pc = rel_target(pc_ff, i_instr.offset);
				cycles = `CMBE_CYC_TWO;
			end
			cmbe_pkg::OP_INDIRECT_BRANCH:
			begin
				nxt_pc = {8'h00, i_pointer_pair};
				cycles = `CMBE_CYC_TWO;
			end
			cmbe_pkg::OP_EXTENDED_INDIRECT_BRANCH:
			begin
				nxt_pc = {eih_ff, i_pointer_pair};
				cycles = `CMBE_CYC_TWO;
			end
			cmbe_pkg::OP_INDIRECT_SUBROUTINE_CALL:
			begin
				do_push = 1'b1;
				nxt_pc  = {8'h00, i_pointer_pair};
				cycles  = `CMBE_CYC_FOUR;
			end
			cmbe_pkg::OP_EXTENDED_INDIRECT_SUBROUTINE_CALL:
			begin
				do_push = 1'b1;
				nxt_pc  = {eih_ff, i_pointer_pair};
				cycles  = `CMBE_CYC_FOUR;
			end
			cmbe_pkg::OP_DIRECT_SUBROUTINE_CALL:
			begin
				// The call itself is two words long, so resume after both.
				do_push   = 1'b1;
				push_addr = pc_ff + 24'h000002;
				nxt_pc    = i_instr.abs_addr;
				cycles    = `CMBE_CYC_FIVE;
			end
			cmbe_pkg::OP_SUBROUTINE_RETURN:
			begin
				do_pop = 1'b1;
				nxt_pc = i_stack_addr;
				cycles = `CMBE_CYC_FIVE;
			end
			cmbe_pkg::OP_INTERRUPT_RETURN:
			begin
				do_pop = 1'b1;
				nxt_pc = i_stack_addr;
				nxt_flags[`CMBE_FLAG_I] = 1'b1;
				cycles = `CMBE_CYC_FIVE;
			end
			cmbe_pkg::OP_COMPARE_SKIP_EQUAL:
			begin
				is_skip  = 1'b1;
				skip_hit = (i_instr.rd_val == i_instr.rr_val);
			end
			cmbe_pkg::OP_REGISTER_COMPARE:
				nxt_flags = sub_flags(i_instr.rd_val, i_instr.rr_val, 1'b0,
					flags_ff, 1'b0);
			cmbe_pkg::OP_REGISTER_COMPARE_CARRY:
				nxt_flags = sub_flags(i_instr.rd_val, i_instr.rr_val,
					flags_ff[`CMBE_FLAG_C], flags_ff, 1'b1);
			cmbe_pkg::OP_IMMEDIATE_COMPARE:
				nxt_flags = sub_flags(i_instr.rd_val, i_instr.imm, 1'b0,
					flags_ff, 1'b0);
			cmbe_pkg::OP_SKIP_REG_BIT_CLEAR:
			begin
				is_skip  = 1'b1;
				skip_hit = ~i_instr.rr_val[i_instr.bit_sel];
			end
			cmbe_pkg::OP_SKIP_REG_BIT_SET:
			begin
				is_skip  = 1'b1;
				skip_hit = i_instr.rr_val[i_instr.bit_sel];
			end
			cmbe_pkg::OP_SKIP_IO_BIT_CLEAR:
			begin
				is_skip  = 1'b1;
				skip_hit = ~i_io_byte[i_instr.bit_sel];
			end
			cmbe_pkg::OP_SKIP_IO_BIT_SET:
			begin
				is_skip  = 1'b1;
				skip_hit = i_io_byte[i_instr.bit_sel];
			end
			cmbe_pkg::OP_BRANCH_FLAG_SET, cmbe_pkg::OP_BRANCH_FLAG_CLEAR:
			begin
				// The 12-bit offset field is sign-extended here by rel_target.
				if (flags_ff[i_instr.bit_sel] ==
					(i_instr.op == cmbe_pkg::OP_BRANCH_FLAG_SET))
				begin
					nxt_pc = rel_target(pc_ff, i_instr.offset);
					cycles = `CMBE_CYC_TWO;
				end
			end
			default:
				cycles = `CMBE_CYC_ONE;
		endcase
		if (is_skip & skip_hit)
		begin
			// Skipping a two-word instruction costs one more step.
			nxt_pc = pc_ff + (i_instr.next_two_words ? 24'h000003 : 24'h000002);
			cycles = i_instr.next_two_words ? `CMBE_CYC_THREE : `CMBE_CYC_TWO;
		end
	end

	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			cmbe_pkg::ST_IDLE:
				if (accept & (cycles != `CMBE_CYC_ONE))
					nxt_state = cmbe_pkg::ST_BUSY;
			cmbe_pkg::ST_BUSY:
				if (wait_ff == 3'h1)
					nxt_state = cmbe_pkg::ST_IDLE;
			default:
				nxt_state = cmbe_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			state_ff <= cmbe_pkg::ST_IDLE;
		else
			state_ff <= nxt_state;
	end

	// Results take effect at acceptance; the wait only holds off the next one.
	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			wait_ff <= 3'h0;
		else if (accept)
			wait_ff <= cycles - 3'h1;
		else if (wait_ff != 3'h0)
			wait_ff <= wait_ff - 3'h1;
	end

	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			pc_ff <= `CMBE_PC_RST;
		else if (accept)
			pc_ff <= nxt_pc;
	end

	// An executing instruction wins over a software write in the same cycle.
	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			flags_ff <= `CMBE_FLAGS_RST;
		else if (accept)
			flags_ff <= nxt_flags;
		else if (sw_flag_wr)
			flags_ff <= i_hwdata[7:0];
	end

	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_pair_wr <= '0;
			o_stack   <= '0;
			o_done    <= 1'b0;
		end
		else
		begin
			o_pair_wr.valid   <= accept & do_pair_wr;
			o_pair_wr.data    <= pair_data;
			o_stack.push      <= accept & do_push;
			o_stack.pop       <= accept & do_pop;
			o_stack.push_addr <= push_addr;
			o_done            <= (accept & (cycles == `CMBE_CYC_ONE)) |
				((state_ff == cmbe_pkg::ST_BUSY) & (wait_ff == 3'h1));
		end
	end

	assign o_pc           = pc_ff;
	assign o_status_flags = flags_ff;

endmodule : cmbe_core
`default_nettype wire

// >>> verif/cmbe_core_props.sv
// Concurrent checks on the instruction port of the execution core.
`timescale 1ns/10ps
`default_nettype none

module cmbe_core_props
(
	// Clock and reset
	input wire logic                       i_mclk,
	input wire logic                       i_rst_n,
	// Instruction port
	input wire logic                       i_instr_valid,
	input wire cmbe_pkg::cmbe_instr_type   i_instr,
	input wire logic                       o_instr_ready,
	input wire logic                       o_done,
	input wire logic [23:0]                i_stack_addr,
	// Results
	input wire cmbe_pkg::cmbe_pair_wr_type o_pair_wr,
	input wire cmbe_pkg::cmbe_stack_type   o_stack,
	input wire logic [23:0]                o_pc,
	input wire logic [7:0]                 o_status_flags
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);

	logic       acc;
	logic [4:0] op;
	logic [7:0] a;
	logic [7:0] b;
	assign acc = i_instr_valid && o_instr_ready;
	assign op  = i_instr.op;
	assign a   = i_instr.rd_val;
	assign b   = i_instr.rr_val;

	property p_test;
		acc && op == 5'h00 |=> o_done && o_status_flags[1] == ($past(a) == 8'h00)
			&& o_status_flags[2] == $past(a[7]) && !o_status_flags[3];
	endproperty
	a_test: assert property (p_test) else $error("zero test flags wrong");

	property p_mul;
		acc && op == 5'h01 |=> o_pair_wr.valid && !o_done
			&& o_pair_wr.data == {8'h00, $past(a)} * {8'h00, $past(b)} ##1 o_done;
	endproperty
	a_mul: assert property (p_mul) else $error("product or timing wrong");

	property p_rel;
		acc && op == 5'h07 |=> !o_done && o_pc == $past(o_pc) + 24'h1
			+ {{12{$past(i_instr.offset[11])}}, $past(i_instr.offset)} ##1 o_done;
	endproperty
	a_rel: assert property (p_rel) else $error("relative target wrong");

	property p_indirect_subroutine_call;
		acc && op == 5'h0A |=> o_stack.push && o_stack.push_addr == $past(o_pc) + 24'h1
			&& !o_done ##1 !o_done [*2] ##1 o_done;
	endproperty
	a_indirect_subroutine_call: assert property (p_indirect_subroutine_call) else $error("indirect call wrong");

	property p_call;
		acc && op == 5'h0C |=> o_pc == $past(i_instr.abs_addr)
			&& o_stack.push_addr == $past(o_pc) + 24'h2 ##4 o_done;
	endproperty
	a_call: assert property (p_call) else $error("direct call wrong");

	property p_interrupt_return;
		acc && op == 5'h0E |=> o_pc == $past(i_stack_addr) && o_status_flags[7]
			&& o_stack.pop ##4 o_done;
	endproperty
	a_interrupt_return: assert property (p_interrupt_return) else $error("interrupt return wrong");

	property p_skip;
		acc && op == 5'h0F && a == b && i_instr.next_two_words
			|=> o_pc == $past(o_pc) + 24'h3 ##2 o_done;
	endproperty
	a_skip: assert property (p_skip) else $error("long skip wrong");

	property p_bru;
		acc && op == 5'h17 && !o_status_flags[i_instr.bit_sel]
			|=> o_pc == $past(o_pc) + 24'h1 && o_done;
	endproperty
	a_bru: assert property (p_bru) else $error("untaken branch wrong");
endmodule : cmbe_core_props

`default_nettype wire

// >>> verif/cmbe_stack_model.sv
// Behavioural data stack that hands return addresses to the core.
`timescale 1ns/10ps
`default_nettype none

module cmbe_stack_model
(
	// Clock and reset
	input  wire logic                     i_mclk,
	input  wire logic                     i_rst_n,
	// Stack traffic
	input  wire cmbe_pkg::cmbe_stack_type i_stack,
	output logic [23:0]                   o_top
);
	logic [23:0] mem_ff [8];
	logic [3:0]  sp_ff;

	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			sp_ff <= 4'h0;
		else if (i_stack.push)
		begin
			mem_ff[sp_ff[2:0]] <= i_stack.push_addr;
			sp_ff <= sp_ff + 4'h1;
		end
		else if (i_stack.pop && sp_ff != 4'h0)
			sp_ff <= sp_ff - 4'h1;
	end

	// An empty stack shows a wrong value, so a return from nothing never looks right.
	assign o_top = (sp_ff == 4'h0) ? ~mem_ff[0] : mem_ff[sp_ff[2:0] - 3'h1];
endmodule : cmbe_stack_model

`default_nettype wire

// >>> verif/tb_top.sv
// Self-checking testbench for the execution core.
`timescale 1ns/10ps
`default_nettype none
`include "cmbe_params.svh"

module tb_top;
	typedef struct
	{
		logic [4:0]  op;
		logic [7:0]  a;
		logic [7:0]  b;
		logic [11:0] k;
		logic [2:0]  bs;
		logic        w;
		logic [15:0] p;
		int          cyc;
		logic        ab;
		logic [23:0] pv;
		logic [1:0]  st;
		logic [15:0] pr;
		logic [7:0]  fv;
	} cmbe_row_type;

	logic                       i_mclk = 1'b0;
	logic                       i_rst_n = 1'b0;
	logic                       i_instr_valid = 1'b0;
	cmbe_pkg::cmbe_instr_type   i_instr = '0;
	logic [15:0]                i_pointer_pair = 16'h0;
	logic [7:0]                 i_io_byte = 8'h0;
	logic [23:0]                i_stack_addr;
	logic                       o_instr_ready;
	logic                       o_done;
	cmbe_pkg::cmbe_pair_wr_type o_pair_wr;
	cmbe_pkg::cmbe_stack_type   o_stack;
	logic [23:0]                o_pc;
	logic [7:0]                 o_status_flags;
	logic                       i_hsel = 1'b0;
	logic [31:0]                i_haddr = 32'h0;
	logic [1:0]                 i_htrans = 2'h0;
	logic                       i_hwrite = 1'b0;
	logic [2:0]                 i_hsize = 3'h0;
	logic [31:0]                i_hwdata = 32'h0;
	logic                       i_hready;
	logic                       o_hreadyout;
	logic                       o_hresp;
	logic [31:0]                o_hrdata;
	logic [31:0]                rd;
	logic [23:0]                cur;
	logic [23:0]                exp_pc;
	logic [23:0]                stkq [$];
	int                         mismatches = 0;
	int                         n_compared = 0;
	int                         ticks = 0;

	// Rows: op, rd, rr, offset or immediate, bit, two-word next, pointer or I/O byte,
	// cycles, absolute target, target or step, stack action, product, flags under 8'hAF.
	cmbe_row_type rows[] = '{
		'{5'h00, 8'h80, 8'h00, 12'h0, 3'h0, 1'b0, 16'h0, 1, 1'b0, 24'h1, 2'h0, 16'h0, 8'h04},
		'{5'h01, 8'hFF, 8'hFF, 12'h0, 3'h0, 1'b0, 16'h0, 2, 1'b0, 24'h1, 2'h0, 16'hFE01, 8'h05},
		'{5'h02, 8'h80, 8'h80, 12'h0, 3'h0, 1'b0, 16'h0, 2, 1'b0, 24'h1, 2'h0, 16'h4000, 8'h04},
		'{5'h03, 8'hFF, 8'h02, 12'h0, 3'h0, 1'b0, 16'h0, 2, 1'b0, 24'h1, 2'h0, 16'hFFFE, 8'h05},
		'{5'h04, 8'h80, 8'h80, 12'h0, 3'h0, 1'b0, 16'h0, 2, 1'b0, 24'h1, 2'h0, 16'h8000, 8'h04},
		'{5'h05, 8'h40, 8'h40, 12'h0, 3'h0, 1'b0, 16'h0, 2, 1'b0, 24'h1, 2'h0, 16'h2000, 8'h04},
		'{5'h06, 8'hC0, 8'h80, 12'h0, 3'h0, 1'b0, 16'h0, 2, 1'b0, 24'h1, 2'h0, 16'hC000, 8'h05},
		'{5'h07, 8'h00, 8'h00, 12'hFFE, 3'h0, 1'b0, 16'h0, 2, 1'b0, 24'hFFFFFF, 2'h0, 16'h0, 8'h05},
		'{5'h08, 8'h00, 8'h00, 12'h0, 3'h0, 1'b0, 16'h1234, 2, 1'b1, 24'h1234, 2'h0, 16'h0, 8'h05},
		'{5'h09, 8'h00, 8'h00, 12'h0, 3'h0, 1'b0, 16'h2222, 2, 1'b1, 24'h5A2222, 2'h0, 16'h0, 8'h05},
		'{5'h0A, 8'h00, 8'h00, 12'h0, 3'h0, 1'b0, 16'h0100, 4, 1'b1, 24'h100, 2'h1, 16'h0, 8'h05},
		'{5'h0B, 8'h00, 8'h00, 12'h0, 3'h0, 1'b0, 16'h0300, 4, 1'b1, 24'h5A0300, 2'h1, 16'h0, 8'h05},
		'{5'h0C, 8'h00, 8'h00, 12'h0, 3'h0, 1'b0, 16'h0, 5, 1'b1, 24'hABCD, 2'h2, 16'h0, 8'h05},
		'{5'h0F, 8'h33, 8'h33, 12'h0, 3'h0, 1'b1, 16'h0, 3, 1'b0, 24'h3, 2'h0, 16'h0, 8'h05},
		'{5'h0F, 8'h33, 8'h34, 12'h0, 3'h0, 1'b0, 16'h0, 1, 1'b0, 24'h1, 2'h0, 16'h0, 8'h05},
		'{5'h10, 8'h10, 8'h20, 12'h0, 3'h0, 1'b0, 16'h0, 1, 1'b0, 24'h1, 2'h0, 16'h0, 8'h05},
		'{5'h11, 8'h20, 8'h1F, 12'h0, 3'h0, 1'b0, 16'h0, 1, 1'b0, 24'h1, 2'h0, 16'h0, 8'h20},
		'{5'h12, 8'h42, 8'h00, 12'h42, 3'h0, 1'b0, 16'h0, 1, 1'b0, 24'h1, 2'h0, 16'h0, 8'h02},
		'{5'h13, 8'hFE, 8'hFE, 12'h0, 3'h0, 1'b0, 16'h0, 2, 1'b0, 24'h2, 2'h0, 16'h0, 8'h02},
		'{5'h14, 8'hFE, 8'hFE, 12'h0, 3'h0, 1'b0, 16'h0, 1, 1'b0, 24'h1, 2'h0, 16'h0, 8'h02},
		'{5'h15, 8'h00, 8'h00, 12'h0, 3'h7, 1'b0, 16'h80, 1, 1'b0, 24'h1, 2'h0, 16'h0, 8'h02},
		'{5'h16, 8'h00, 8'h00, 12'h0, 3'h7, 1'b1, 16'h80, 3, 1'b0, 24'h3, 2'h0, 16'h0, 8'h02},
		'{5'h17, 8'h00, 8'h00, 12'h4, 3'h1, 1'b0, 16'h0, 2, 1'b0, 24'h5, 2'h0, 16'h0, 8'h02},
		'{5'h18, 8'h00, 8'h00, 12'h4, 3'h1, 1'b0, 16'h0, 1, 1'b0, 24'h1, 2'h0, 16'h0, 8'h02},
		'{5'h17, 8'h00, 8'h00, 12'h4, 3'h0, 1'b0, 16'h0, 1, 1'b0, 24'h1, 2'h0, 16'h0, 8'h02},
		'{5'h18, 8'h00, 8'h00, 12'h4, 3'h0, 1'b0, 16'h0, 2, 1'b0, 24'h5, 2'h0, 16'h0, 8'h02},
		'{5'h0D, 8'h00, 8'h00, 12'h0, 3'h0, 1'b0, 16'h0, 5, 1'b0, 24'h0, 2'h3, 16'h0, 8'h02},
		'{5'h0E, 8'h00, 8'h00, 12'h0, 3'h0, 1'b0, 16'h0, 5, 1'b0, 24'h0, 2'h3, 16'h0, 8'h82}
	};

	assign i_hready = o_hreadyout;

	always #25 i_mclk = ~i_mclk;

	cmbe_core dut (.i_mclk, .i_rst_n, .i_instr_valid, .i_instr, .o_instr_ready, .o_done,
		.i_pointer_pair, .i_io_byte, .i_stack_addr, .o_pair_wr, .o_stack, .o_pc,
		.o_status_flags, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hsize, .i_hwdata,
		.i_hready, .o_hreadyout, .o_hresp, .o_hrdata);

	cmbe_stack_model u_stack (.i_mclk, .i_rst_n, .i_stack(o_stack), .o_top(i_stack_addr));

	task automatic cmp_val(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e)
		begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : cmp_val

	task automatic wrap_up;
		$display("compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : wrap_up

	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
		@(posedge i_mclk);
		i_hsel <= 1'b1;
		i_htrans <= 2'h2;
		i_haddr <= a;
		i_hwrite <= wr;
		i_hsize <= 3'h2;
		do @(posedge i_mclk); while (i_hready !== 1'b1);
		i_hsel <= 1'b0;
		i_htrans <= 2'h0;
		i_hwdata <= wd;
		do @(posedge i_mclk); while (i_hready !== 1'b1);
		rd = o_hrdata;
		cmp_val({30'h0, o_hreadyout, o_hresp}, 32'h2);
	endtask : bus

	task automatic run_row(input cmbe_row_type r);
		int                         n;
		cmbe_pkg::cmbe_pair_wr_type pw;
		cmbe_pkg::cmbe_stack_type   sw;
		@(posedge i_mclk);
		cur = o_pc;
		i_instr <= '{cmbe_pkg::cmbe_op_type'(r.op), r.a, r.b, r.k[7:0], r.k, r.bs, r.pv, r.w};
		i_pointer_pair <= r.p;
		i_io_byte <= r.p[7:0];
		i_instr_valid <= 1'b1;
		do @(posedge i_mclk); while (o_instr_ready !== 1'b1);
		i_instr_valid <= 1'b0;
		#1;
		pw = o_pair_wr;
		sw = o_stack;
		n = 1;
		while (o_done !== 1'b1 && n < 9)
		begin
			@(posedge i_mclk);
			#1;
			n++;
		end
		exp_pc = (r.st == 2'h3) ? stkq.pop_back() : (r.ab ? r.pv : cur + r.pv);
		cmp_val(32'(n), 32'(r.cyc));
		cmp_val({8'h0, o_pc}, {8'h0, exp_pc});
		cmp_val({24'h0, o_status_flags & 8'hAF}, {24'h0, r.fv});
		if (r.op inside {[5'h01:5'h06]})
			cmp_val({15'h0, pw.valid, pw.data}, {15'h0, 1'b1, r.pr});
		if (r.st == 2'h1 || r.st == 2'h2)
		begin
			cmp_val({7'h0, sw.push, sw.push_addr}, {7'h0, 1'b1, cur + 24'(r.st)});
			stkq.push_back(cur + 24'(r.st));
		end
		if (r.st == 2'h3)
			cmp_val({31'h0, sw.pop}, 32'h1);
	endtask : run_row

	always @(posedge i_mclk)
	begin
		ticks++;
		if (ticks == 4000)
		begin
			mismatches++;
			wrap_up();
		end
	end

	initial
	begin
		repeat (20) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		bus(1'b1, {24'h0, `CMBE_CTRL_OFFS}, 32'h1);
		bus(1'b1, {24'h0, `CMBE_EIH_OFFS}, 32'h5A);
		bus(1'b0, {24'h0, `CMBE_EIH_OFFS}, 32'h0);
		cmp_val(rd, 32'h5A);
		foreach (rows[i])
		begin
			run_row(rows[i]);
			$display("row %0d done", i);
		end
		bus(1'b0, {24'h0, `CMBE_PC_OFFS}, 32'h0);
		cmp_val(rd, {8'h0, exp_pc});
		$display("register read done");
		// A reset in mid-multiply must abandon the operation and leave the run bit off.
		@(posedge i_mclk);
		i_instr <= '{cmbe_pkg::OP_PRODUCT_UNSIGNED, 8'h3, 8'h3, 8'h0, 12'h0, 3'h0, 24'h0, 1'b0};
		i_instr_valid <= 1'b1;
		do @(posedge i_mclk); while (o_instr_ready !== 1'b1);
		i_rst_n <= 1'b0;
		#1;
		cmp_val({5'h0, o_instr_ready, o_done, o_pair_wr.valid, o_pc}, 32'h0);
		cmp_val({24'h0, o_status_flags}, 32'h0);
		repeat (20) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		repeat (3) @(posedge i_mclk);
		i_instr_valid <= 1'b0;
		#1;
		cmp_val({7'h0, o_instr_ready, o_pc}, 32'h0);
		bus(1'b0, 32'h10, 32'h0);
		cmp_val(rd, 32'h0);
		bus(1'b0, {24'h0, `CMBE_FLAGS_OFFS}, 32'h0);
		cmp_val(rd, 32'h0);
		$display("reset test done");
		// Software may load the flags directly while the core is stopped.
		bus(1'b1, {24'h0, `CMBE_FLAGS_OFFS}, 32'hC3);
		bus(1'b0, {24'h0, `CMBE_FLAGS_OFFS}, 32'h0);
		cmp_val(rd, 32'hC3);
		$display("flag write test done");
		wrap_up();
	end
endmodule : tb_top

bind cmbe_core cmbe_core_props u_props (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
	.i_instr_valid(i_instr_valid), .i_instr(i_instr), .o_instr_ready(o_instr_ready),
	.o_done(o_done), .i_stack_addr(i_stack_addr), .o_pair_wr(o_pair_wr),
	.o_stack(o_stack), .o_pc(o_pc), .o_status_flags(o_status_flags));

`default_nettype wire
